// file: logic/drfb_pkg.sv
// package: constants and carrier structs for the rename / forward / bypass block
`default_nettype none
package drfb_pkg;
  localparam int unsigned NUM_PHYS = 32;
  localparam int unsigned NUM_ARCH = 8;
  localparam int unsigned PW = 5;
  localparam int unsigned AW = 3;
  localparam int unsigned DW = 32;
  localparam int unsigned MAW = 32;
  localparam logic [NUM_PHYS-1:0] FREE_RST = 32'hffffff00;
  localparam logic [NUM_PHYS-1:0] PINNED_RST = 32'h000000ff;
  localparam logic [1:0] BYP_WAIT_CYC = 2'h1;

  typedef enum logic [1:0] {
    DRFB_OP_ALU = 2'b00,
    DRFB_OP_MOVE = 2'b01,
    DRFB_OP_OTHER = 2'b10
  } drfb_op_e;

  typedef struct packed {
    logic valid;
    drfb_op_e op;
    logic src_is_reg;
    logic [AW-1:0] src_reg;
    logic src_is_mem;
    logic [1:0] src_size;
    logic dst_is_reg;
    logic [AW-1:0] dst_reg;
    logic dst_is_mem;
    logic [1:0] dst_size;
    logic [MAW-1:0] mem_addr;
    logic mem_cacheable;
  } drfb_inst_s;

  typedef struct packed {
    logic valid;
    logic [PW-1:0] preg;
    logic [DW-1:0] data;
  } drfb_wb_s;

  typedef struct packed {
    logic fwd_operand;
    logic fwd_result;
    logic fwd_result_mem;
    logic bypass;
    logic interlock;
  } drfb_ctl_s;

  typedef enum logic [1:0] {
    DRFB_ST_RUN = 2'b00,
    DRFB_ST_BYP = 2'b01,
    DRFB_ST_LOCK = 2'b10
  } drfb_state_e;
endpackage : drfb_pkg
`default_nettype wire

// file: logic/drfb_core.sv
// module: dependency rename, forwarding and bypass control for the X/Y pair
`timescale 1ns/10ps
`default_nettype none
module drfb_core (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire drfb_pkg::drfb_inst_s x_inst_in,
  input wire drfb_pkg::drfb_inst_s y_inst_in,
  input wire drfb_pkg::drfb_wb_s x_wb_in,
  input wire drfb_pkg::drfb_wb_s y_wb_in,
  input wire logic [drfb_pkg::PW-1:0] retire_preg_in,
  input wire logic retire_in,
  output logic issue_ready_out,
  output logic y_stall_out,
  output logic [drfb_pkg::PW-1:0] x_src_preg_out,
  output logic [drfb_pkg::PW-1:0] y_src_preg_out,
  output logic [drfb_pkg::PW-1:0] x_dst_preg_out,
  output logic [drfb_pkg::PW-1:0] y_dst_preg_out,
  output logic [drfb_pkg::PW-1:0] x_old_preg_out,
  output logic [drfb_pkg::PW-1:0] y_old_preg_out,
  output drfb_pkg::drfb_ctl_s ctl_out,
  output logic mem_rd_skip_out,
  output logic mem_wr_from_x_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // logical to physical map, one entry per architectural register
  logic [drfb_pkg::PW-1:0] map_ff [drfb_pkg::NUM_ARCH];
  // free: may be handed out; ready: value written back; pinned: mapped or displaced
  logic [drfb_pkg::NUM_PHYS-1:0] free_ff;
  logic [drfb_pkg::NUM_PHYS-1:0] ready_ff;
  logic [drfb_pkg::NUM_PHYS-1:0] pinned_ff;
  // pair control state and the physical register an interlock waits on
  drfb_pkg::drfb_state_e state_ff;
  drfb_pkg::drfb_state_e nxt_state;
  logic [drfb_pkg::PW-1:0] wait_preg_ff;
  logic [drfb_pkg::PW-1:0] nxt_wait_preg;
  drfb_pkg::drfb_ctl_s ctl_ff;
  drfb_pkg::drfb_ctl_s nxt_ctl;
  // registered issue answers, held until the next accepted pair
  logic [drfb_pkg::PW-1:0] xs_ff; // X source read
  logic [drfb_pkg::PW-1:0] ys_ff; // Y source read
  logic [drfb_pkg::PW-1:0] xd_ff; // X fresh destination
  logic [drfb_pkg::PW-1:0] yd_ff; // Y fresh destination
  logic [drfb_pkg::PW-1:0] xo_ff; // register displaced by X
  logic [drfb_pkg::PW-1:0] yo_ff; // register displaced by Y

  // ----------------------------------------------------------------
  // free-pool search: lowest and next-lowest free physical registers
  // ----------------------------------------------------------------
  logic [drfb_pkg::PW-1:0] alloc_a;
  logic [drfb_pkg::PW-1:0] alloc_b;
  logic have_a;
  logic have_b;
  // one priority scan; b takes the next free entry above the one a picked
  always_comb begin
    alloc_a = '0;
    alloc_b = '0;
    have_a = 1'b0;
    have_b = 1'b0;
    // lowest index first keeps the choice repeatable from run to run
    for (int i = 0; i < drfb_pkg::NUM_PHYS; i++) begin
      if (free_ff[i] && !have_a) begin
        alloc_a = drfb_pkg::PW'(i);
        have_a = 1'b1;
      end else if (free_ff[i] && !have_b) begin
        alloc_b = drfb_pkg::PW'(i);
        have_b = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // dependency decode between X (first) and Y (second)
  // ----------------------------------------------------------------
  // pair qualifiers; X is always the older instruction of the two
  wire both_v = x_inst_in.valid && y_inst_in.valid;
  wire x_wr = x_inst_in.valid && x_inst_in.dst_is_reg;
  wire y_wr = y_inst_in.valid && y_inst_in.dst_is_reg;

  // read-after-write through a logical register
  wire reg_raw = both_v && x_inst_in.dst_is_reg && y_inst_in.src_is_reg &&
                 (x_inst_in.dst_reg == y_inst_in.src_reg);
  // read-after-write through one memory word, matched on the full address
  wire mem_raw = both_v && x_inst_in.dst_is_mem && y_inst_in.src_is_mem &&
                 (x_inst_in.mem_addr == y_inst_in.mem_addr);
  // write-after-write on one logical register; Y is the later writer and keeps the map
  wire waw_pair = x_wr && y_wr && (x_inst_in.dst_reg == y_inst_in.dst_reg);

  // operation classes and the size match that forwarding depends on
  wire x_move = (x_inst_in.op == drfb_pkg::DRFB_OP_MOVE);
  wire y_move = (y_inst_in.op == drfb_pkg::DRFB_OP_MOVE);
  wire size_eq = (x_inst_in.dst_size == y_inst_in.src_size);
  // operand forwarding: X move's single read also feeds Y
  wire can_opfwd = reg_raw && x_move && size_eq;
  // result forwarding: X result written to Y move destination too
  wire can_resfwd = reg_raw && !x_move && y_move;
  // bypass: a cacheable write in X is handed to the read in Y
  wire can_bypass = mem_raw && x_inst_in.mem_cacheable;
  // every other register read-after-write waits for the producer
  wire need_lock = reg_raw && !can_opfwd && !can_resfwd;
  // a non-cacheable memory RAW also waits on X, then reads memory normally
  wire mem_lock = mem_raw && !x_inst_in.mem_cacheable;

  // allocation needs one free register per writer; Y takes the second scan result
  // whenever X is present, so the pair never names one register for both slots;
  // the cost is that such a pair wants two free entries even if X writes memory
  wire y_second = x_inst_in.valid;
  wire need_two = y_second && y_wr;
  wire alloc_ok = need_two ? have_b : ((x_wr || y_wr) ? have_a : 1'b1);
  wire running = (state_ff == drfb_pkg::DRFB_ST_RUN);
  // a low ce_in blocks the take as well as every register update
  wire accept = ce_in && running && alloc_ok && (x_inst_in.valid || y_inst_in.valid);
  wire [drfb_pkg::PW-1:0] x_new = alloc_a;
  wire [drfb_pkg::PW-1:0] y_new = y_second ? alloc_b : alloc_a;
  // Y sources see X's rename when Y reads X's destination
  wire [drfb_pkg::PW-1:0] y_src_map = reg_raw ? x_new : map_ff[y_inst_in.src_reg];

  // ----------------------------------------------------------------
  // interlock release
  // ----------------------------------------------------------------
  // physical register the producer writes, recorded for the interlock wait
  wire [drfb_pkg::PW-1:0] lock_preg = x_new;
  wire x_wb_hit = x_wb_in.valid && (x_wb_in.preg == wait_preg_ff);
  wire y_wb_hit = y_wb_in.valid && (y_wb_in.preg == wait_preg_ff);
  // the ready bit also ends the wait, so a write-back is never lost to a busy
  // cycle; a free entry never counts, its ready bit is stale
  wire lock_ready = ready_ff[wait_preg_ff] && !free_ff[wait_preg_ff];
  wire wb_hit = x_wb_hit || y_wb_hit || lock_ready;

  // ----------------------------------------------------------------
  // pair control state: run, one-clock bypass wait, interlock wait
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_wait_preg = wait_preg_ff;
    nxt_ctl = '0;
    unique case (state_ff)
      // run: take a pair and latch its hazard flags for one clock
      drfb_pkg::DRFB_ST_RUN: begin
        if (accept) begin
          nxt_ctl.fwd_operand = can_opfwd;
          nxt_ctl.fwd_result = can_resfwd;
          nxt_ctl.fwd_result_mem = can_resfwd && y_inst_in.dst_is_mem;
          nxt_ctl.bypass = can_bypass;
          nxt_ctl.interlock = need_lock || mem_lock;
          if (can_bypass) begin
            nxt_state = drfb_pkg::DRFB_ST_BYP;
          end else if (need_lock || mem_lock) begin
            nxt_state = drfb_pkg::DRFB_ST_LOCK;
            nxt_wait_preg = lock_preg;
          end
        end
      end
      // bypass: the held write data reaches Y during this single stall clock
      drfb_pkg::DRFB_ST_BYP: begin
        nxt_state = drfb_pkg::DRFB_ST_RUN;
      end
      // interlock: hold Y until the producer's register is written back
      drfb_pkg::DRFB_ST_LOCK: begin
        if (wb_hit) begin
          nxt_state = drfb_pkg::DRFB_ST_RUN;
        end
      end
      // the spare code cannot be reached; fall back to run
      default: nxt_state = drfb_pkg::DRFB_ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // rename table: later writer in program order wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int a = 0; a < drfb_pkg::NUM_ARCH; a++) begin
        // identity map; the upper physical registers start in the free pool
        map_ff[a] <= drfb_pkg::PW'(a);
      end
    end else if (accept) begin
      if (x_wr) begin
        map_ff[x_inst_in.dst_reg] <= x_new;
      end
      // Y is assigned last, so on a shared logical register the later writer wins
      if (y_wr) begin
        map_ff[y_inst_in.dst_reg] <= y_new;
      end
    end
  end

  // ----------------------------------------------------------------
  // pool bookkeeping: free, ready and pinned bits per physical register
  // ----------------------------------------------------------------
  // a register stays pinned from allocation until its displaced mapping retires;
  // retire of an older mapping is what frees it, so in-flight readers are safe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      free_ff <= drfb_pkg::FREE_RST;
      ready_ff <= drfb_pkg::PINNED_RST;
      pinned_ff <= drfb_pkg::PINNED_RST;
    end else if (ce_in) begin
      // retire first so a same-cycle allocation below wins the bits
      if (retire_in && pinned_ff[retire_preg_in]) begin
        free_ff[retire_preg_in] <= 1'b1;
        pinned_ff[retire_preg_in] <= 1'b0;
      end
      // write-backs may arrive in any order, each marks only its own register
      if (x_wb_in.valid) begin
        ready_ff[x_wb_in.preg] <= 1'b1;
      end
      if (y_wb_in.valid) begin
        ready_ff[y_wb_in.preg] <= 1'b1;
      end
      // allocation last: it wins over a retire or a write-back of the same entry
      if (accept && x_wr) begin
        free_ff[x_new] <= 1'b0;
        pinned_ff[x_new] <= 1'b1;
        ready_ff[x_new] <= 1'b0;
      end
      if (accept && y_wr) begin
        free_ff[y_new] <= 1'b0;
        pinned_ff[y_new] <= 1'b1;
        ready_ff[y_new] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered issue outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= drfb_pkg::DRFB_ST_RUN;
      wait_preg_ff <= '0;
      ctl_ff <= '0;
      xs_ff <= '0;
      ys_ff <= '0;
      xd_ff <= '0;
      yd_ff <= '0;
      xo_ff <= '0;
      yo_ff <= '0;
    end else if (ce_in) begin
      // everything here freezes while ce_in is low
      state_ff <= nxt_state;
      wait_preg_ff <= nxt_wait_preg;
      ctl_ff <= nxt_ctl;
      // source numbers use the map as it stood before this pair's renames, except a Y read of X's destination gets X's fresh register unless operand-forwarded
      if (accept) begin
        xs_ff <= map_ff[x_inst_in.src_reg];
        // operand forwarding hands Y the same read as X
        ys_ff <= can_opfwd ? map_ff[x_inst_in.src_reg] : y_src_map;
        // fresh destinations; a slot that writes no register reports a spare number
        xd_ff <= x_new;
        yd_ff <= y_new;
        // displaced registers go back to retire; when both write one logical
        // register, Y displaces X's fresh register rather than the old mapping
        xo_ff <= map_ff[x_inst_in.dst_reg];
        yo_ff <= waw_pair ? x_new : map_ff[y_inst_in.dst_reg];
      end
    end
  end

  // ----------------------------------------------------------------
  // output decode; physical numbers only go to the register file, never to software
  // ----------------------------------------------------------------
  // handshake: a pair is taken on a rising edge with this high, ce_in high and a slot valid
  assign issue_ready_out = running && alloc_ok;
  // only bypass and interlock stall Y; false dependencies never do
  assign y_stall_out = !running;
  // physical numbers for the register file side
  assign x_src_preg_out = xs_ff;
  assign y_src_preg_out = ys_ff;
  assign x_dst_preg_out = xd_ff;
  assign y_dst_preg_out = yd_ff;
  assign x_old_preg_out = xo_ff;
  assign y_old_preg_out = yo_ff;
  // one-clock hazard flags; the cache skips its read for a bypassed Y
  // and takes X's result straight into its write path
  assign ctl_out = ctl_ff;
  assign mem_rd_skip_out = ctl_ff.bypass;
  assign mem_wr_from_x_out = ctl_ff.fwd_result_mem;
endmodule : drfb_core
`default_nettype wire

// file: dv/drfb_wb_model.sv
// partner model: write-back side that answers a held producer
`timescale 1ns/10ps
`default_nettype none
module drfb_wb_model #(parameter int DLY = 3) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic lock_in,
  input wire logic [drfb_pkg::PW-1:0] preg_in,
  output drfb_pkg::drfb_wb_s wb_out
);
  int cnt;
  // a slow producer reports DLY cycles late; data is unused, so it toggles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      wb_out <= '0;
    end else begin
      wb_out.valid <= (cnt == 1);
      wb_out.preg <= preg_in;
      wb_out.data <= ~wb_out.data;
      cnt <= lock_in ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule : drfb_wb_model
`default_nettype wire

// file: dv/drfb_core_properties.sv
// checker: timing relations between the dependency block outputs
`timescale 1ns/10ps
`default_nettype none
module drfb_core_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic issue_ready_out,
  input wire logic y_stall_out,
  input wire logic [drfb_pkg::PW-1:0] x_dst_preg_out,
  input wire logic [drfb_pkg::PW-1:0] y_dst_preg_out,
  input wire logic [drfb_pkg::PW-1:0] x_old_preg_out,
  input wire drfb_pkg::drfb_ctl_s ctl_out,
  input wire logic mem_rd_skip_out,
  input wire logic mem_wr_from_x_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  byp_one_stall_a: assert property (ctl_out.bypass |-> y_stall_out ##1 !y_stall_out)
    else $error("bypass stall not exactly one clock");
  skip_is_byp_a: assert property (mem_rd_skip_out == ctl_out.bypass)
    else $error("read skip differs from bypass");
  wr_is_resmem_a: assert property (mem_wr_from_x_out == ctl_out.fwd_result_mem)
    else $error("direct write differs from result to memory");
  resmem_fwd_a: assert property (ctl_out.fwd_result_mem |-> ctl_out.fwd_result)
    else $error("result to memory without result forwarding");
  lock_stalls_a: assert property (ctl_out.interlock |-> y_stall_out)
    else $error("interlock without stall");
  stall_blocks_a: assert property (y_stall_out |-> !issue_ready_out)
    else $error("issue ready during stall");
  opfwd_nostall_a: assert property (ctl_out.fwd_operand |-> !y_stall_out)
    else $error("operand forwarding stalled");
  byp_flag_pulse_a: assert property (ctl_out.bypass |=> !ctl_out.bypass)
    else $error("bypass flag held");
  pair_dst_a: assert property ($changed(x_dst_preg_out) && $changed(y_dst_preg_out)
    |-> x_dst_preg_out != y_dst_preg_out)
    else $error("pair shares a destination");
  dst_fresh_a: assert property ($changed(x_dst_preg_out) |-> x_dst_preg_out != x_old_preg_out)
    else $error("destination equals displaced register");
endmodule : drfb_core_properties
bind drfb_core drfb_core_properties chk_u (.clk_in, .rst_n_in, .issue_ready_out, .y_stall_out,
  .x_dst_preg_out, .y_dst_preg_out, .x_old_preg_out, .ctl_out, .mem_rd_skip_out,
  .mem_wr_from_x_out);
`default_nettype wire

// file: dv/tb_dependency_rename_forward_bypass.sv
// testbench: scenarios for rename, forwarding, bypass and interlock
`timescale 1ns/10ps
`default_nettype none
module tb_dependency_rename_forward_bypass;
  logic clk_in, rst_n_in, ce_in, retire_in, issue_ready_out, y_stall_out;
  logic mem_rd_skip_out, mem_wr_from_x_out;
  logic [4:0] retire_preg_in, x_src_preg_out, y_src_preg_out, x_dst_preg_out;
  logic [4:0] y_dst_preg_out, x_old_preg_out, y_old_preg_out, ax;
  drfb_pkg::drfb_inst_s x_inst_in, y_inst_in;
  drfb_pkg::drfb_wb_s x_wb_in, y_wb_in;
  drfb_pkg::drfb_ctl_s ctl_out;
  int mismatches = 0;
  int checked = 0;
  drfb_core dut_u (.clk_in, .rst_n_in, .ce_in, .x_inst_in, .y_inst_in, .x_wb_in, .y_wb_in,
    .retire_preg_in, .retire_in, .issue_ready_out, .y_stall_out, .x_src_preg_out,
    .y_src_preg_out, .x_dst_preg_out, .y_dst_preg_out, .x_old_preg_out, .y_old_preg_out,
    .ctl_out, .mem_rd_skip_out, .mem_wr_from_x_out);
  // two producers: X answers held pairs, Y answers forwarded moves
  drfb_wb_model xm_u (.clk_in, .rst_n_in, .lock_in(ctl_out.interlock),
    .preg_in(x_dst_preg_out), .wb_out(x_wb_in));
  drfb_wb_model ym_u (.clk_in, .rst_n_in, .lock_in(ctl_out.fwd_result),
    .preg_in(y_dst_preg_out), .wb_out(y_wb_in));
  always #10 clk_in = ~clk_in;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic c);
    checked++;
    if (c !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: output differs", $time);
    end
  endtask : chk
  // k: src reg, src mem, dst reg, dst mem
  function automatic drfb_pkg::drfb_inst_s mk(drfb_pkg::drfb_op_e op, logic [2:0] sr,
    logic [2:0] dr, logic [3:0] k, logic [1:0] sz, logic ca);
    mk = '{1'b1, op, k[3], sr, k[2], sz, k[1], dr, k[0], 2'h2, 32'h0000_0100, ca};
  endfunction : mk
  // hold the pair until taken, bounded; returns at the edge after outputs land
  task automatic issue(input drfb_pkg::drfb_inst_s x, input drfb_pkg::drfb_inst_s y);
    int n;
    n = 0;
    x_inst_in = x;
    y_inst_in = y;
    while (issue_ready_out !== 1'b1 && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    chk(n < 50);
    @(negedge clk_in);
    x_inst_in = '0;
    y_inst_in = '0;
  endtask : issue
  task automatic s_rename();
    issue(mk(drfb_pkg::DRFB_OP_ALU, 0, 0, 4'ha, 2, 1), mk(drfb_pkg::DRFB_OP_MOVE, 0, 0, 4'h6, 2, 1));
    chk(ctl_out === '0 && y_stall_out === 1'b0);
    chk(x_dst_preg_out >= 5'h08 && y_dst_preg_out >= 5'h08);
    chk(x_old_preg_out === 5'h00 && y_old_preg_out === x_dst_preg_out);
    ax = y_dst_preg_out;
    retire_preg_in = x_old_preg_out;
    retire_in = 1'b1;
    @(negedge clk_in);
    retire_in = 1'b0;
  endtask : s_rename
  task automatic s_operand();
    issue(mk(drfb_pkg::DRFB_OP_MOVE, 0, 1, 4'ha, 2, 1), mk(drfb_pkg::DRFB_OP_ALU, 1, 2, 4'ha, 2, 1));
    chk(x_src_preg_out === ax);
    chk(y_src_preg_out === ax);
    chk(ctl_out.fwd_operand === 1'b1 && y_stall_out === 1'b0);
  endtask : s_operand
  task automatic s_result();
    for (int d = 0; d < 2; d++) begin
      issue(mk(drfb_pkg::DRFB_OP_ALU, 1, 2, 4'ha, 2, 1),
        mk(drfb_pkg::DRFB_OP_MOVE, 2, 3, d ? 4'h9 : 4'ha, 2, 1));
      chk(ctl_out.fwd_result === 1'b1 && y_stall_out === 1'b0);
      chk(y_src_preg_out === x_dst_preg_out);
      chk(ctl_out.fwd_result_mem === d[0] && mem_wr_from_x_out === d[0]);
    end
  endtask : s_result
  // cacheable pair bypasses with one stall, the other interlocks on the producer
  task automatic s_memraw();
    int n;
    for (int c = 1; c >= 0; c--) begin
      issue(mk(drfb_pkg::DRFB_OP_ALU, 0, 0, 4'h9, 2, c[0]),
        mk(drfb_pkg::DRFB_OP_ALU, 0, 1, 4'h6, 2, c[0]));
      chk(mem_rd_skip_out === c[0] && ctl_out.interlock === !c[0]);
      chk(y_stall_out === 1'b1);
      n = 0;
      while (y_stall_out === 1'b1 && n < 20) begin
        @(negedge clk_in);
        n++;
      end
      chk(c ? n == 1 : n >= 2 && n < 20);
    end
  endtask : s_memraw
  task automatic s_sizes();
    issue(mk(drfb_pkg::DRFB_OP_MOVE, 0, 1, 4'ha, 2, 1), mk(drfb_pkg::DRFB_OP_ALU, 1, 2, 4'ha, 1, 1));
    chk(ctl_out.fwd_operand === 1'b0 && ctl_out.interlock === 1'b1);
    repeat (12) @(negedge clk_in);
    chk(issue_ready_out === 1'b1);
  endtask : s_sizes
  // clock enable low: a presented pair is not taken; then a renamed WAW pair
  task automatic s_freeze();
    ax = y_dst_preg_out;
    ce_in = 1'b0;
    x_inst_in = mk(drfb_pkg::DRFB_OP_ALU, 3, 3, 4'ha, 2, 1);
    y_inst_in = mk(drfb_pkg::DRFB_OP_ALU, 5, 3, 4'ha, 2, 1);
    repeat (3) @(negedge clk_in);
    chk(y_dst_preg_out === ax && ctl_out === '0);
    ce_in = 1'b1;
    @(negedge clk_in);
    x_inst_in = '0;
    y_inst_in = '0;
    chk(y_dst_preg_out !== ax && y_stall_out === 1'b0);
    chk(y_old_preg_out === x_dst_preg_out);
  endtask : s_freeze
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    retire_in = 1'b0;
    retire_preg_in = '0;
    x_inst_in = '0;
    y_inst_in = '0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    s_rename();
    s_operand();
    s_result();
    s_memraw();
    s_sizes();
    s_freeze();
    give_verdict();
  end
  // every scenario finishes within a few hundred cycles
  initial begin
    #(20 * 4000);
    mismatches++;
    give_verdict();
  end
endmodule : tb_dependency_rename_forward_bypass
`default_nettype wire
